// ### pkg/tmr_defines.svh
// offsets, field positions, reset values and timing counts of the timer
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// ************************************************************
// register offsets on the 8-bit register port
// ************************************************************
`define TMR_ADDR_CTRL_A 4'h0
`define TMR_ADDR_CTRL_B 4'h1
`define TMR_ADDR_CNT_LO 4'h2
`define TMR_ADDR_CNT_HI 4'h3
`define TMR_ADDR_CAP_LO 4'h4
`define TMR_ADDR_CAP_HI 4'h5
`define TMR_ADDR_CMPA_LO 4'h6
`define TMR_ADDR_CMPA_HI 4'h7
`define TMR_ADDR_FLAGS 4'h8
`define TMR_ADDR_IRQ_EN 4'h9
`define TMR_ADDR_CMP_CS 4'ha
// ************************************************************
// field positions
// ************************************************************
`define TMR_B_NF 7
`define TMR_B_EDGE 6
`define TMR_B_WGM_HI 4
`define TMR_B_WGM_LO 3
`define TMR_B_CS_HI 2
`define TMR_A_WGM_HI 1
`define TMR_F_OVF 0
`define TMR_F_CAP 1
`define TMR_AC_SEL 2
// ************************************************************
// reset values and fixed counts
// ************************************************************
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_MAX 16'hffff
`define TMR_TOP_8 16'h00ff
`define TMR_TOP_9 16'h01ff
`define TMR_TOP_10 16'h03ff
`define TMR_NF_SAMPLES 4
// prescaler masks: tick when the masked bits are all ones
`define TMR_PRE_8 10'h007
`define TMR_PRE_64 10'h03f
`define TMR_PRE_256 10'h0ff
`define TMR_PRE_1024 10'h3ff
`endif

// ### pkg/tmr_pkg.sv
// types shared by the timer design files
package tmr_pkg;
  // ************************************************************
  // counting direction of dual-slope modes
  // ************************************************************
  typedef enum logic [0:0] {
    TMR_UP = 1'b0,
    TMR_DOWN = 1'b1
  } tmr_dir_e;
  // waveform mode field
  typedef logic [3:0] tmr_mode_t;
endpackage

// ### logic/tmr_sync.sv
// three-flop synchroniser plus hold flop that passes a change once s2 and s3 agree
module tmr_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  // ************************************************************
  // synchroniser chain
  // ************************************************************
  logic s1_ff; // first stage, read only by s2
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  // stage shift and agreement hold
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= (s2_ff == s3_ff) ? s3_ff : out_ff;
    end
  end
  assign sync_out = out_ff;
endmodule

// ### logic/tmr_tick_gen.sv
// timer tick source: prescaled core clock or external pin edge
`include "tmr_defines.svh"
module tmr_tick_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] tick_source_select,
  input wire logic ext_tick_sync,
  output logic timer_tick
);
  // ************************************************************
  // prescaler and external edge
  // ************************************************************
  logic [9:0] pre_ff; // free running prescaler
  logic ext_prev_ff; // last external level
  logic ext_rise; // rising edge on pin
  logic ext_fall; // falling edge on pin
  // prescaler counts every core cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 10'h000;
      ext_prev_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 10'h001;
      ext_prev_ff <= ext_tick_sync;
    end
  end
  assign ext_rise = ext_tick_sync & ~ext_prev_ff;
  assign ext_fall = ~ext_tick_sync & ext_prev_ff;
  // source and edge selection
  always_comb begin
    case (tick_source_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = (pre_ff & `TMR_PRE_8) == `TMR_PRE_8;
      3'h3: timer_tick = (pre_ff & `TMR_PRE_64) == `TMR_PRE_64;
      3'h4: timer_tick = (pre_ff & `TMR_PRE_256) == `TMR_PRE_256;
      3'h5: timer_tick = (pre_ff & `TMR_PRE_1024) == `TMR_PRE_1024;
      3'h6: timer_tick = ext_fall;
      3'h7: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end
  // ************************************************************
  // checks
  // ************************************************************
  stop_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick_source_select == 3'h0 |-> !timer_tick)
    else $error("tick while source is off");
endmodule

// ### logic/tmr_core.sv
// 16-bit timer counter with shared byte latch and input capture
//
// Operation
// - one latch write serves several low writes
// - source select zero stops the counter
// - counter clears, increments or decrements per tick
// - top and floor indications from the counter
// - low count read loads latch with upper
// - low count write loads latch plus byte
// - software count write beats counting
// - count access works with ticks stopped
// - four-bit mode split over two controls
// - overflow flag set where mode says
// - matching edge copies count into capture
// - capture flag set same cycle as copy
// - enabled capture flag raises irq, clears
// - capture low read loads latch with upper
// - capture writable only in capture-top modes
// - comparator select switches capture trigger source
// - filter changes after four equal samples
// - filter enable bit, core clock, latency
// - capture input off in capture-top modes
// - capture pin sampled regardless of direction
// - new capture overwrites previous value
// - top from fixed values, compare or capture
// - tick from prescaler or external pin edge
`include "tmr_defines.svh"
module tmr_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic external_tick_pin,
  input wire logic ovf_irq_ack,
  input wire logic cap_irq_ack,
  output logic ovf_irq,
  output logic cap_irq,
  output logic at_top,
  output logic at_count_floor
);
  // ************************************************************
  // mode decoding functions
  // ************************************************************
  // top value of the sequence for a mode
  function automatic logic [15:0] mode_top(
    input tmr_pkg::tmr_mode_t m,
    input logic [15:0] cmpa,
    input logic [15:0] cap
  );
    case (m)
      4'h1, 4'h5: mode_top = `TMR_TOP_8;
      4'h2, 4'h6: mode_top = `TMR_TOP_9;
      4'h3, 4'h7: mode_top = `TMR_TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: mode_top = cmpa;
      4'h8, 4'ha, 4'hc, 4'he: mode_top = cap;
      default: mode_top = `TMR_MAX;
    endcase
  endfunction
  // mode counts up then down
  function automatic logic mode_dual(input tmr_pkg::tmr_mode_t m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: mode_dual = 1'b1;
      default: mode_dual = 1'b0;
    endcase
  endfunction
  // mode uses the capture register as top
  function automatic logic mode_cap_top(input tmr_pkg::tmr_mode_t m);
    case (m)
      4'h8, 4'ha, 4'hc, 4'he: mode_cap_top = 1'b1;
      default: mode_cap_top = 1'b0;
    endcase
  endfunction
  // mode clears at its compare or capture top and flags at max
  function automatic logic mode_ctc(input tmr_pkg::tmr_mode_t m);
    mode_ctc = (m == 4'h4) || (m == 4'hc);
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] control_reg_a_ff; // mode low bits
  logic [7:0] control_reg_b_ff; // filter, edge, mode high, source
  logic [7:0] comparator_ctrl_status_ff; // trigger source select
  logic [1:0] irq_en_ff; // overflow and capture enables
  logic [15:0] count_value_ff; // the counter
  logic [15:0] capture_register_ff; // captured time stamp
  logic [15:0] compare_a_register_ff; // compare value used as top
  logic [7:0] temp_ff; // shared high-byte latch
  logic overflow_flag_ff; // sticky overflow
  logic capture_flag_ff; // sticky capture
  logic [7:0] rdata_ff; // read answer, one cycle late
  tmr_pkg::tmr_dir_e dir_ff; // dual-slope direction
  logic [3:0] nf_hist_ff; // last filter samples
  logic nf_out_ff; // filtered trigger level
  logic edge_prev_ff; // last level seen by edge detector

  // ************************************************************
  // decode
  // ************************************************************
  tmr_pkg::tmr_mode_t waveform_mode_field;
  logic [2:0] tick_source_select;
  logic noise_filter_enable;
  logic capture_rising;
  logic comparator_capture_select;
  logic [15:0] top_value;
  logic is_dual;
  logic is_cap_top;
  logic wr_ctrl_a, wr_ctrl_b, wr_cmp_cs, wr_irq_en, wr_flags;
  logic wr_cnt_lo, wr_cnt_hi, wr_cap_lo, wr_cap_hi;
  logic wr_cmpa_lo, wr_cmpa_hi;
  logic rd_cnt_lo, rd_cap_lo;
  logic wr_cap_ok;
  logic latch_load;
  logic [7:0] latch_next;
  logic [7:0] nxt_rdata;

  assign waveform_mode_field = {
    control_reg_b_ff[`TMR_B_WGM_HI:`TMR_B_WGM_LO],
    control_reg_a_ff[`TMR_A_WGM_HI:0]};
  assign tick_source_select = control_reg_b_ff[`TMR_B_CS_HI:0];
  assign noise_filter_enable = control_reg_b_ff[`TMR_B_NF];
  assign capture_rising = control_reg_b_ff[`TMR_B_EDGE];
  assign comparator_capture_select =
    comparator_ctrl_status_ff[`TMR_AC_SEL];
  assign top_value = mode_top(waveform_mode_field,
    compare_a_register_ff, capture_register_ff);
  assign is_dual = mode_dual(waveform_mode_field);
  assign is_cap_top = mode_cap_top(waveform_mode_field);

  // write and read strobes per location
  assign wr_ctrl_a = reg_wr && (reg_addr == `TMR_ADDR_CTRL_A);
  assign wr_ctrl_b = reg_wr && (reg_addr == `TMR_ADDR_CTRL_B);
  assign wr_cmp_cs = reg_wr && (reg_addr == `TMR_ADDR_CMP_CS);
  assign wr_irq_en = reg_wr && (reg_addr == `TMR_ADDR_IRQ_EN);
  assign wr_flags = reg_wr && (reg_addr == `TMR_ADDR_FLAGS);
  assign wr_cnt_lo = reg_wr && (reg_addr == `TMR_ADDR_CNT_LO);
  assign wr_cnt_hi = reg_wr && (reg_addr == `TMR_ADDR_CNT_HI);
  assign wr_cap_lo = reg_wr && (reg_addr == `TMR_ADDR_CAP_LO);
  assign wr_cap_hi = reg_wr && (reg_addr == `TMR_ADDR_CAP_HI);
  assign wr_cmpa_lo = reg_wr && (reg_addr == `TMR_ADDR_CMPA_LO);
  assign wr_cmpa_hi = reg_wr && (reg_addr == `TMR_ADDR_CMPA_HI);
  assign rd_cnt_lo = reg_rd && (reg_addr == `TMR_ADDR_CNT_LO);
  assign rd_cap_lo = reg_rd && (reg_addr == `TMR_ADDR_CAP_LO);
  assign wr_cap_ok = wr_cap_lo && is_cap_top;

  // ************************************************************
  // shared high-byte latch
  // ************************************************************
  // every high write loads it; count and capture low reads fill it; low writes leave it
  assign latch_load = wr_cnt_hi || wr_cap_hi || wr_cmpa_hi ||
                      rd_cnt_lo || rd_cap_lo;
  assign latch_next = rd_cnt_lo ? count_value_ff[15:8] :
                      rd_cap_lo ? capture_register_ff[15:8] :
                      reg_wdata;
  // latch register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= `TMR_RST_BYTE;
    end else if (latch_load) begin
      temp_ff <= latch_next;
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  // upper locations of count and capture return the latch
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `TMR_ADDR_CTRL_A: nxt_rdata = control_reg_a_ff;
      `TMR_ADDR_CTRL_B: nxt_rdata = control_reg_b_ff;
      `TMR_ADDR_CNT_LO: nxt_rdata = count_value_ff[7:0];
      `TMR_ADDR_CNT_HI: nxt_rdata = temp_ff;
      `TMR_ADDR_CAP_LO: nxt_rdata = capture_register_ff[7:0];
      `TMR_ADDR_CAP_HI: nxt_rdata = temp_ff;
      `TMR_ADDR_CMPA_LO: nxt_rdata = compare_a_register_ff[7:0];
      `TMR_ADDR_CMPA_HI: nxt_rdata = compare_a_register_ff[15:8];
      `TMR_ADDR_FLAGS: nxt_rdata = {6'h00, capture_flag_ff,
                                    overflow_flag_ff};
      `TMR_ADDR_IRQ_EN: nxt_rdata = {6'h00, irq_en_ff};
      `TMR_ADDR_CMP_CS: nxt_rdata = comparator_ctrl_status_ff;
      default: nxt_rdata = 8'h00; // unmapped reads zero
    endcase
  end
  // answer stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `TMR_RST_BYTE;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg_a_ff <= `TMR_RST_BYTE;
      control_reg_b_ff <= `TMR_RST_BYTE;
      comparator_ctrl_status_ff <= `TMR_RST_BYTE;
      irq_en_ff <= 2'h0;
    end else begin
      if (wr_ctrl_a) control_reg_a_ff <= reg_wdata;
      if (wr_ctrl_b) control_reg_b_ff <= reg_wdata;
      if (wr_cmp_cs) comparator_ctrl_status_ff <= reg_wdata;
      if (wr_irq_en) irq_en_ff <= reg_wdata[1:0];
    end
  end
  // compare register, written through the latch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_register_ff <= `TMR_RST_WORD;
    end else if (wr_cmpa_lo) begin
      compare_a_register_ff <= {temp_ff, reg_wdata};
    end
  end

  // ************************************************************
  // tick source
  // ************************************************************
  logic ext_tick_sync;
  logic timer_tick;
  tmr_sync u_sync_ext (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(external_tick_pin),
    .sync_out(ext_tick_sync)
  );
  tmr_tick_gen u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_source_select(tick_source_select),
    .ext_tick_sync(ext_tick_sync),
    .timer_tick(timer_tick)
  );

  // ************************************************************
  // counter unit
  // ************************************************************
  logic [15:0] nxt_count;
  tmr_pkg::tmr_dir_e nxt_dir;
  logic ovf_event;
  assign at_top = (count_value_ff == top_value);
  assign at_count_floor = (count_value_ff == `TMR_RST_WORD);
  // next count; a software low write wins over any tick
  always_comb begin
    nxt_count = count_value_ff;
    nxt_dir = dir_ff;
    if (wr_cnt_lo) begin
      nxt_count = {temp_ff, reg_wdata};
    end else if (timer_tick && is_dual) begin
      if (dir_ff == tmr_pkg::TMR_UP) begin
        if (count_value_ff >= top_value) begin
          nxt_dir = tmr_pkg::TMR_DOWN;
          nxt_count = count_value_ff - 16'h0001;
        end else begin
          nxt_count = count_value_ff + 16'h0001;
        end
      end else if (at_count_floor) begin
        nxt_dir = tmr_pkg::TMR_UP;
        nxt_count = count_value_ff + 16'h0001;
      end else begin
        nxt_count = count_value_ff - 16'h0001;
      end
    end else if (timer_tick) begin
      // single slope: clear at top, else count up
      nxt_count = at_top ? `TMR_RST_WORD :
                  count_value_ff + 16'h0001;
    end
  end
  // overflow point depends on the mode
  assign ovf_event = timer_tick && !wr_cnt_lo && (
    is_dual ? (dir_ff == tmr_pkg::TMR_DOWN && at_count_floor) :
    mode_ctc(waveform_mode_field) ? (count_value_ff == `TMR_MAX) :
    at_top);
  // counter and direction registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_ff <= `TMR_RST_WORD;
      dir_ff <= tmr_pkg::TMR_UP;
    end else begin
      count_value_ff <= nxt_count;
      dir_ff <= nxt_dir;
    end
  end

  // ************************************************************
  // input capture: sync, source mux, noise filter, edge detect
  // ************************************************************
  logic cap_pin_sync;
  logic comp_sync;
  logic trig_level;
  logic nf_all_equal;
  logic edge_level;
  logic cap_event;
  // pin level sampled whatever its port direction
  tmr_sync u_sync_cap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(capture_pin),
    .sync_out(cap_pin_sync)
  );
  tmr_sync u_sync_comp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(comparator_output),
    .sync_out(comp_sync)
  );
  assign trig_level = comparator_capture_select ? comp_sync :
                      cap_pin_sync;
  assign nf_all_equal = (nf_hist_ff == 4'hf) || (nf_hist_ff == 4'h0);
  assign edge_level = noise_filter_enable ? nf_out_ff : trig_level;
  // filter on the core clock: four equal samples move the output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nf_hist_ff <= 4'h0;
      nf_out_ff <= 1'b0;
      edge_prev_ff <= 1'b0;
    end else begin
      nf_hist_ff <= {nf_hist_ff[2:0], trig_level};
      if (nf_all_equal) nf_out_ff <= nf_hist_ff[0];
      edge_prev_ff <= edge_level;
    end
  end
  // chosen edge; input ignored when capture register is top
  assign cap_event = !is_cap_top &&
    (capture_rising ? (edge_level && !edge_prev_ff) :
                      (!edge_level && edge_prev_ff));
  // capture register: every event overwrites
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_register_ff <= `TMR_RST_WORD;
    end else if (cap_event) begin
      capture_register_ff <= count_value_ff;
    end else if (wr_cap_ok) begin
      capture_register_ff <= {temp_ff, reg_wdata};
    end
  end

  // ************************************************************
  // sticky flags; a set in the clear cycle wins
  // ************************************************************
  logic clr_ovf;
  logic clr_cap;
  assign clr_ovf = (wr_flags && reg_wdata[`TMR_F_OVF]) || ovf_irq_ack;
  assign clr_cap = (wr_flags && reg_wdata[`TMR_F_CAP]) ||
                   cap_irq_ack;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_ff <= 1'b0;
      capture_flag_ff <= 1'b0;
    end else begin
      overflow_flag_ff <= ovf_event || (overflow_flag_ff && !clr_ovf);
      capture_flag_ff <= cap_event ||
                         (capture_flag_ff && !clr_cap);
    end
  end
  assign ovf_irq = overflow_flag_ff && irq_en_ff[`TMR_F_OVF];
  assign cap_irq = capture_flag_ff && irq_en_ff[`TMR_F_CAP];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  cap_copy_a: assert property (cap_event |=>
    capture_register_ff == $past(count_value_ff) && capture_flag_ff)
    else $error("capture did not copy count with flag");
  cap_flag_a: assert property ($rose(capture_flag_ff) |->
    capture_register_ff == $past(count_value_ff))
    else $error("capture flag rose without a copy");
  cnt_write_a: assert property (wr_cnt_lo |=>
    count_value_ff == {$past(temp_ff), $past(reg_wdata)})
    else $error("count write lost to counting");
  latch_read_a: assert property (rd_cnt_lo ##1 reg_rd &&
    reg_addr == `TMR_ADDR_CNT_HI |=> reg_rdata == $past(count_value_ff[15:8], 2))
    else $error("upper count read wrong byte");
  stop_cnt_a: assert property (tick_source_select == 3'h0 &&
    !wr_cnt_lo |=> count_value_ff == $past(count_value_ff))
    else $error("stopped counter moved");
  wrap_top_a: assert property (timer_tick && !is_dual && at_top &&
    !wr_cnt_lo |=> count_value_ff == `TMR_RST_WORD && (overflow_flag_ff ||
    $past(mode_ctc(waveform_mode_field))))
    else $error("single slope did not wrap at top");
  cap_off_a: assert property (is_cap_top && !wr_cap_ok |=>
    $stable(capture_register_ff) && !$rose(capture_flag_ff))
    else $error("capture in capture-top mode");
  flag_clr_a: assert property (capture_flag_ff && clr_cap &&
    !cap_event |=> !capture_flag_ff)
    else $error("capture flag not cleared");
  filt_wait_a: assert property (noise_filter_enable &&
    $changed(nf_out_ff) |-> $past(nf_all_equal))
    else $error("filter moved without four equal samples");
  cap_seen_c: cover property (cap_event ##1 capture_flag_ff);
  ovf_seen_c: cover property (ovf_event && is_dual);
  dir_turn_c: cover property (dir_ff == tmr_pkg::TMR_UP ##1
    dir_ff == tmr_pkg::TMR_DOWN);
  filt_cap_c: cover property (noise_filter_enable && cap_event);
endmodule

// ### verif/tmr_cpu_model.sv
// processor side of the timer register port
module tmr_cpu_model (
  input wire logic core_clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle from time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // one read strobe cycle, data held only in the next cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // high byte loads the latch, low byte commits the word
  task automatic w16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // low byte first, high byte returns the latch; strobes back to back
  task automatic r16(input logic [3:0] lo, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= lo;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_addr <= lo + 4'h1;
    @(negedge core_clk);
    v[7:0] = reg_rdata;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v[15:8] = reg_rdata;
  endtask
endmodule

// ### verif/tb_tmr_core.sv
// self-checking bench for the timer core
`include "tmr_defines.svh"
module tb_tmr_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic reg_wr, reg_rd, ovf_irq, cap_irq, at_top, at_count_floor;
  logic capture_pin = 1'b0;
  logic comp_out = 1'b0;
  logic external_tick_pin = 1'b0;
  logic cap_irq_ack = 1'b0;
  logic [15:0] v;
  int bad_count = 0;
  int n_compared = 0;
  always #50 core_clk = ~core_clk;
  tmr_core DUT (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_pin(capture_pin), .comparator_output(comp_out),
    .external_tick_pin(external_tick_pin), .ovf_irq_ack(1'b0),
    .cap_irq_ack(cap_irq_ack), .ovf_irq(ovf_irq), .cap_irq(cap_irq),
    .at_top(at_top), .at_count_floor(at_count_floor));
  tmr_cpu_model cpu (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // value compare, counted
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // capture pin level, then settle through sync and filter
  task automatic pin(input logic l, input int n);
    @(posedge core_clk) capture_pin <= l;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // word access via shared latch, ticks stopped
  task automatic t_latch;
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h01ff);
    cpu.wr(`TMR_ADDR_CMPA_LO, 8'h34);
    cpu.r16(`TMR_ADDR_CNT_LO, v);
    chk("count", 16'h01ff, v);
    cpu.r16(`TMR_ADDR_CMPA_LO, v);
    chk("cmpa", 16'h0134, v);
    repeat (20) @(posedge core_clk);
    cpu.r16(`TMR_ADDR_CNT_LO, v);
    chk("stopped", 16'h01ff, v);
  endtask
  // three external rising edges advance the count by three
  task automatic t_ext;
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h0000);
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h07);
    repeat (3) begin
      @(posedge core_clk) external_tick_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      external_tick_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h00);
    cpu.r16(`TMR_ADDR_CNT_LO, v);
    chk("ext", 16'h0003, v);
  endtask
  // wrap through top, floor and overflow flag
  task automatic t_wrap;
    int i;
    cpu.wr(`TMR_ADDR_IRQ_EN, 8'h01);
    cpu.w16(`TMR_ADDR_CNT_LO, 16'hfff0);
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h01);
    for (i = 0; i < 40 && at_top !== 1'b1; i++) @(negedge core_clk);
    chk("top", 16'h0001, 16'(at_top));
    for (i = 0; i < 4 && at_count_floor !== 1'b1; i++)
      @(negedge core_clk);
    chk("floor", 16'h0001, 16'(at_count_floor));
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h00);
    cpu.rd(`TMR_ADDR_FLAGS, b);
    chk("ovf", 16'h0001, 16'(b));
    chk("ovf irq", 16'h0001, 16'(ovf_irq));
    cpu.wr(`TMR_ADDR_FLAGS, 8'h01);
    cpu.rd(`TMR_ADDR_FLAGS, b);
    chk("ovf clr", 16'h0000, 16'(b));
    chk("ovf irq clr", 16'h0000, 16'(ovf_irq));
  endtask
  // edges, filter, overwrite and interrupt clear
  task automatic t_cap;
    cpu.wr(`TMR_ADDR_IRQ_EN, 8'h02);
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h40);
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h1234);
    pin(1'b1, 16);
    chk("irq", 16'h0001, 16'(cap_irq));
    cpu.r16(`TMR_ADDR_CAP_LO, v);
    chk("cap", 16'h1234, v);
    cpu.rd(`TMR_ADDR_FLAGS, b);
    chk("flag", 16'h0002, 16'(b));
    @(posedge core_clk) cap_irq_ack <= 1'b1;
    @(posedge core_clk) cap_irq_ack <= 1'b0;
    @(negedge core_clk);
    chk("ack", 16'h0000, 16'(cap_irq));
    cpu.wr(`TMR_ADDR_CTRL_B, 8'hc0);
    pin(1'b0, 16);
    pin(1'b1, 2);
    pin(1'b0, 16);
    chk("glitch", 16'h0000, 16'(cap_irq));
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h5678);
    pin(1'b1, 16);
    chk("filt", 16'h0001, 16'(cap_irq));
    cpu.r16(`TMR_ADDR_CAP_LO, v);
    chk("over", 16'h5678, v);
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h00);
    cpu.wr(`TMR_ADDR_FLAGS, 8'h02);
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h0abc);
    pin(1'b0, 16);
    cpu.r16(`TMR_ADDR_CAP_LO, v);
    chk("fall", 16'h0abc, v);
  endtask
  // capture as top: writable; pin rises with falling edge selected, no flag
  task automatic t_mode;
    cpu.wr(`TMR_ADDR_FLAGS, 8'h03);
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h18);
    cpu.w16(`TMR_ADDR_CAP_LO, 16'h0040);
    cpu.r16(`TMR_ADDR_CAP_LO, v);
    chk("capw", 16'h0040, v);
    pin(1'b1, 16);
    cpu.rd(`TMR_ADDR_FLAGS, b);
    chk("nocap", 16'h0000, 16'(b));
  endtask
  // comparator output as trigger source
  task automatic t_comp;
    cpu.wr(`TMR_ADDR_CTRL_B, 8'h40);
    cpu.w16(`TMR_ADDR_CNT_LO, 16'h0777);
    cpu.wr(`TMR_ADDR_CMP_CS, 8'h04);
    cpu.wr(`TMR_ADDR_FLAGS, 8'h02);
    @(posedge core_clk) comp_out <= 1'b1;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    chk("comp irq", 16'h0001, 16'(cap_irq));
    cpu.r16(`TMR_ADDR_CAP_LO, v);
    chk("comp", 16'h0777, v);
  endtask
  initial begin
    #2000000;
    bad_count++;
    results;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_latch;
    t_ext;
    t_wrap;
    t_cap;
    t_mode;
    t_comp;
    results;
  end
endmodule
